// *** verilog/tec_timer.sv ***
// Purpose: 16-bit timer/event counter with two capture/compare registers.
// Assumes: pclk is the peripheral clock; edge inputs are asynchronous pins.
// Notes:   Count ticks are strobes on pclk; APB answers with one wait state.
`timescale 1ns/1ps
`default_nettype none

module tec_timer (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr,
	input  wire logic        edge_input_first,
	input  wire logic        edge_input_second,
	output logic             timer_wave_out,
	output logic             timer_wave_oe,
	output logic             match_irq_first,
	output logic             match_irq_second
);

	////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed {
		logic [1:0]  in1_sync;
		logic        in1_prev;
		logic [1:0]  in2_sync;
		logic        in2_prev;
		logic [15:0] count;
		logic [15:0] cmp1;
		logic [15:0] cmp2;
		logic [3:0]  mode;
		logic [2:0]  ccctl;
		logic [5:0]  outctl;
		logic [7:0]  presc;
		logic [3:0]  div;
		logic        tick_pend;
		logic        cap1_pend;
		logic        cap2_pend;
		logic        wave;
		logic        irq1;
		logic        irq2;
		logic        pready;
		logic [31:0] rdata;
		logic        slverr;
	} tec_state_type;

	tec_state_type state_reg;
	tec_state_type state_next;

	// True when the given edge code accepts the observed edge.
	function automatic logic edge_ok(input logic [1:0] code,
		input logic rise, input logic fall);
		edge_ok = 1'b0;
		unique case (code)
			tec_pkg::EDGE_FALL: edge_ok = fall;
			tec_pkg::EDGE_RISE: edge_ok = rise;
			tec_pkg::EDGE_BOTH: edge_ok = rise | fall;
			default:            edge_ok = 1'b0;
		endcase
	endfunction

	// True when the address names a mapped register.
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == tec_pkg::OFS_COUNT) || (a == tec_pkg::OFS_CMP1) ||
			(a == tec_pkg::OFS_CMP2) || (a == tec_pkg::OFS_MODE) ||
			(a == tec_pkg::OFS_CCCTL) || (a == tec_pkg::OFS_OUTCTL) ||
			(a == tec_pkg::OFS_PRESC);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Decoded terms shared by the next-state logic and the checks.

	logic       rise1;
	logic       fall1;
	logic       rise2;
	logic       fall2;
	logic [1:0] op;
	logic       running;
	logic       ev1;
	logic       ev2;
	logic       opp1;
	logic       cnt_read;
	logic       wr_done;
	logic       raw_tick;
	logic       tick;
	logic       m1;
	logic       m2;
	logic       cap1;
	logic       cap2;
	logic       os_trig;

	// Edges are taken from the second stage only; the first only feeds the second.
	always_comb begin
		rise1 = state_reg.in1_sync[1] & ~state_reg.in1_prev;
		fall1 = ~state_reg.in1_sync[1] & state_reg.in1_prev;
		rise2 = state_reg.in2_sync[1] & ~state_reg.in2_prev;
		fall2 = ~state_reg.in2_sync[1] & state_reg.in2_prev;
		op = state_reg.mode[tec_pkg::MODE_OP_HI:tec_pkg::MODE_OP_LO];
		running = (op != tec_pkg::OP_STOP);
		ev1 = edge_ok(state_reg.presc[tec_pkg::PR_FIRST_LO +: 2],
			rise1, fall1);
		ev2 = edge_ok(state_reg.presc[tec_pkg::PR_SECOND_LO +: 2],
			rise2, fall2);
		// Opposite phase of the first input; code 11 yields nothing.
		opp1 = edge_ok(state_reg.presc[tec_pkg::PR_FIRST_LO +: 2],
			fall1, rise1) &
			(state_reg.presc[tec_pkg::PR_FIRST_LO +: 2] !=
			tec_pkg::EDGE_BOTH);
		cnt_read = psel & penable & ~state_reg.pready & ~pwrite &
			(paddr == tec_pkg::OFS_COUNT);
		wr_done = psel & penable & state_reg.pready & pwrite;
	end

	// Count tick source; a tick that meets a counter read waits a cycle.
	always_comb begin
		unique case (state_reg.presc[tec_pkg::PR_CLK_LO +: 2])
			tec_pkg::CLK_DIV1:  raw_tick = 1'b1;
			tec_pkg::CLK_DIV4:  raw_tick =
				(state_reg.div[1:0] == tec_pkg::DIV4_LAST[1:0]);
			tec_pkg::CLK_DIV16: raw_tick =
				(state_reg.div == tec_pkg::DIV16_LAST);
			tec_pkg::CLK_EDGE:  raw_tick = ev1;
		endcase
		tick = running & (raw_tick | state_reg.tick_pend) &
			~cnt_read;
		m1 = ~state_reg.ccctl[tec_pkg::CC_FIRST_CAP] &
			(state_reg.count == state_reg.cmp1);
		m2 = ~state_reg.ccctl[tec_pkg::CC_SECOND_CAP] &
			(state_reg.count == state_reg.cmp2);
		// Capture triggers; a counter read plays no part here.
		cap1 = running & state_reg.ccctl[tec_pkg::CC_FIRST_CAP] &
			(state_reg.ccctl[tec_pkg::CC_FIRST_SRC] ? opp1 : ev2);
		cap2 = running & state_reg.ccctl[tec_pkg::CC_SECOND_CAP] &
			ev1;
		os_trig = wr_done & (paddr == tec_pkg::OFS_OUTCTL) &
			pwdata[tec_pkg::OC_OS_TRIG] & state_reg.outctl[tec_pkg::OC_OS_EN];
	end

	////////////////////////////////////////////////////////////////////////
	// Next state.

	// Registers are written at the completing APB edge; captures land
	// afterwards so they override a coincident write.
	always_comb begin
		state_next = state_reg;
		state_next.in1_sync = {state_reg.in1_sync[0], edge_input_first};
		state_next.in1_prev = state_reg.in1_sync[1];
		state_next.in2_sync = {state_reg.in2_sync[0], edge_input_second};
		state_next.in2_prev = state_reg.in2_sync[1];
		state_next.div = state_reg.div + 4'h1;
		state_next.tick_pend = running &
			(raw_tick | state_reg.tick_pend) & cnt_read;

		// Register writes; the counter itself ignores writes.
		if (wr_done) begin
			unique case (paddr)
				tec_pkg::OFS_CMP1: state_next.cmp1 = pwdata[15:0];
				tec_pkg::OFS_CMP2: state_next.cmp2 = pwdata[15:0];
				tec_pkg::OFS_MODE: begin
					state_next.mode[3:1] = pwdata[3:1];
					state_next.mode[tec_pkg::MODE_OVF] =
						state_reg.mode[tec_pkg::MODE_OVF] &
						pwdata[tec_pkg::MODE_OVF];
				end
				tec_pkg::OFS_CCCTL:  state_next.ccctl = pwdata[2:0];
				tec_pkg::OFS_OUTCTL: state_next.outctl = pwdata[5:0];
				tec_pkg::OFS_PRESC:  state_next.presc = pwdata[7:0];
				default: ;
			endcase
		end

		// Counter: cleared when stopped or on a clearing event.
		if (!running) begin
			state_next.count = tec_pkg::RST_WORD16;
		end else if ((op == tec_pkg::OP_EDGE_CLEAR) && ev1) begin
			state_next.count = tec_pkg::RST_WORD16;
		end else if (os_trig) begin
			state_next.count = tec_pkg::RST_WORD16;
		end else if (tick) begin
			if ((op == tec_pkg::OP_MATCH_CLEAR) && m1) begin
				state_next.count = tec_pkg::RST_WORD16;
			end else begin
				state_next.count = state_reg.count + 16'h0001;
			end
		end

		// Overflow flag; a wrap wins over a clearing write.
		if (tick && (state_reg.count == tec_pkg::COUNT_TOP) &&
			!((op == tec_pkg::OP_MATCH_CLEAR) && m1)) begin
			state_next.mode[tec_pkg::MODE_OVF] = 1'b1;
		end

		// Captures copy the counter and leave it running.
		if (cap1) begin
			state_next.cmp1 = state_reg.count;
		end
		if (cap2) begin
			state_next.cmp2 = state_reg.count;
		end
		state_next.cap1_pend = cap1;
		state_next.cap2_pend = cap2;
		state_next.irq1 = (tick & m1) | state_reg.cap1_pend;
		state_next.irq2 = (tick & m2) | state_reg.cap2_pend;

		// Wave output toggles on matches, optionally on first-input edges.
		if (!running) begin
			state_next.wave = 1'b0;
		end else if ((tick & (m1 | m2)) |
			(state_reg.mode[tec_pkg::MODE_EDGE_TG] & ev1)) begin
			state_next.wave = ~state_reg.wave;
		end

		// APB: one wait state, read data sampled in the first access cycle.
		state_next.pready = psel & penable & ~state_reg.pready;
		state_next.slverr = psel & penable & ~state_reg.pready &
			~mapped(paddr);
		state_next.rdata = 32'h0000_0000;
		if (psel && penable && !state_reg.pready && !pwrite) begin
			unique case (paddr)
				tec_pkg::OFS_COUNT:  state_next.rdata[15:0] = state_reg.count;
				tec_pkg::OFS_CMP1:   state_next.rdata[15:0] = state_reg.cmp1;
				tec_pkg::OFS_CMP2:   state_next.rdata[15:0] = state_reg.cmp2;
				tec_pkg::OFS_MODE:   state_next.rdata[3:0] = state_reg.mode;
				tec_pkg::OFS_CCCTL:  state_next.rdata[2:0] = state_reg.ccctl;
				tec_pkg::OFS_OUTCTL: state_next.rdata[5:0] = state_reg.outctl;
				tec_pkg::OFS_PRESC:  state_next.rdata[7:0] = state_reg.presc;
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register.

	// All fields take constants under reset.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg.in1_sync  <= 2'b00;
			state_reg.in1_prev  <= 1'b0;
			state_reg.in2_sync  <= 2'b00;
			state_reg.in2_prev  <= 1'b0;
			state_reg.count     <= tec_pkg::RST_WORD16;
			state_reg.cmp1      <= tec_pkg::RST_WORD16;
			state_reg.cmp2      <= tec_pkg::RST_WORD16;
			state_reg.mode      <= tec_pkg::RST_MODE;
			state_reg.ccctl     <= tec_pkg::RST_CCCTL;
			state_reg.outctl    <= tec_pkg::RST_OUTCTL;
			state_reg.presc     <= tec_pkg::RST_PRESC;
			state_reg.div       <= 4'h0;
			state_reg.tick_pend <= 1'b0;
			state_reg.cap1_pend <= 1'b0;
			state_reg.cap2_pend <= 1'b0;
			state_reg.wave      <= 1'b0;
			state_reg.irq1      <= 1'b0;
			state_reg.irq2      <= 1'b0;
			state_reg.pready    <= 1'b0;
			state_reg.rdata     <= 32'h0000_0000;
			state_reg.slverr    <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs come straight from the state register.
	assign pready           = state_reg.pready;
	assign prdata           = state_reg.rdata;
	assign pslverr          = state_reg.slverr;
	assign timer_wave_out   = state_reg.wave;
	assign timer_wave_oe    = state_reg.outctl[tec_pkg::OC_OUT_EN];
	assign match_irq_first  = state_reg.irq1;
	assign match_irq_second = state_reg.irq2;

	////////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_count_step: assert property (
		running && tick && op == tec_pkg::OP_FREE && !ev1 && !os_trig
		|=> state_reg.count == $past(state_reg.count) + 16'h0001)
		else $error("counter did not step by one on a tick");

	chk_read_holds: assert property (
		cnt_read && running && op == tec_pkg::OP_FREE && !os_trig
		|=> state_reg.count == $past(state_reg.count) &&
		(state_reg.tick_pend || !$past(raw_tick)) ##1
		(!$past(state_reg.tick_pend) ||
		state_reg.count == $past(state_reg.count) + 16'h0001))
		else $error("deferred tick lost around a counter read");

	chk_stop_clears: assert property (
		!running |=> state_reg.count == 16'h0000)
		else $error("counter not cleared while stopped");

	chk_match_clear: assert property (
		running && op == tec_pkg::OP_MATCH_CLEAR && tick && m1 && !os_trig
		|=> state_reg.count == 16'h0000 && match_irq_first)
		else $error("match clear did not zero counter with request");

	chk_first_match: assert property (
		tick && m1 |=> match_irq_first)
		else $error("first match request missing");

	chk_second_match: assert property (
		tick && m2 |=> match_irq_second)
		else $error("second match request missing");

	chk_cap_second: assert property (
		cap2 |=> state_reg.cmp2 == $past(state_reg.count) ##1
		match_irq_second)
		else $error("second capture value or request wrong");

	chk_cap_first: assert property (
		cap1 |=> state_reg.cmp1 == $past(state_reg.count) ##1
		match_irq_first)
		else $error("first capture value or request wrong");

	chk_both_none: assert property (
		state_reg.ccctl[tec_pkg::CC_FIRST_SRC] &&
		state_reg.presc[tec_pkg::PR_FIRST_LO +: 2] ==
		tec_pkg::EDGE_BOTH |-> !cap1)
		else $error("capture on both edges of opposite-phase trigger");

	chk_wave_toggle: assert property (
		running && tick && m1 && !$past(running) == 1'b0
		|=> timer_wave_out != $past(timer_wave_out))
		else $error("wave output did not toggle on match");

	chk_apb_wait: assert property (
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("access answer not given after one wait state");

	// A software trigger restarts the count from zero at once.
	chk_oneshot_clear: assert property (
		running && os_trig |=> state_reg.count == 16'h0000)
		else $error("one-shot trigger did not clear counter");

	// Only a real capture may move the second register during a read.
	chk_read_no_cap: assert property (
		cnt_read |=> state_reg.cmp2 == $past(state_reg.cmp2) || $past(cap2))
		else $error("counter read changed second register");

	// A stopped timer leaves its wave output low.
	chk_stop_wave: assert property (
		!running |=> !timer_wave_out)
		else $error("wave output not low while stopped");

endmodule

`default_nettype wire

// *** pkg/tec_pkg.sv ***
// Purpose: Shared constants for the 16-bit timer/event counter block.
// Assumes: APB slave with 32-bit data and 8-bit byte addresses.
// Notes:   Register fields sit in the low bits; unused bits read zero.
package tec_pkg;

	// Byte offsets of the registers on the APB.
	localparam logic [7:0] OFS_COUNT   = 8'h00;
	localparam logic [7:0] OFS_CMP1    = 8'h04;
	localparam logic [7:0] OFS_CMP2    = 8'h08;
	localparam logic [7:0] OFS_MODE    = 8'h0C;
	localparam logic [7:0] OFS_CCCTL   = 8'h10;
	localparam logic [7:0] OFS_OUTCTL  = 8'h14;
	localparam logic [7:0] OFS_PRESC   = 8'h18;

	// Field positions in timer_mode_reg.
	localparam int MODE_OVF     = 0;
	localparam int MODE_EDGE_TG = 1;
	localparam int MODE_OP_LO   = 2;
	localparam int MODE_OP_HI   = 3;

	// Field positions in capcmp_control_reg.
	localparam int CC_FIRST_CAP  = 0;
	localparam int CC_FIRST_SRC  = 1;
	localparam int CC_SECOND_CAP = 2;

	// Field positions in output_control_reg.
	localparam int OC_OUT_EN     = 0;
	localparam int OC_OS_EN      = 5;
	localparam int OC_OS_TRIG    = 6;

	// Field positions in prescaler_mode_reg.
	localparam int PR_CLK_LO   = 0;
	localparam int PR_FIRST_LO = 4;
	localparam int PR_SECOND_LO = 6;

	// Reset values and the top count.
	localparam logic [15:0] RST_WORD16 = 16'h0000;
	localparam logic [3:0]  RST_MODE   = 4'h0;
	localparam logic [2:0]  RST_CCCTL  = 3'h0;
	localparam logic [5:0]  RST_OUTCTL = 6'h00;
	localparam logic [7:0]  RST_PRESC  = 8'h00;
	localparam logic [15:0] COUNT_TOP  = 16'hFFFF;

	// Operating modes held in the two mode bits.
	localparam logic [1:0] OP_STOP       = 2'b00;
	localparam logic [1:0] OP_FREE       = 2'b01;
	localparam logic [1:0] OP_EDGE_CLEAR = 2'b10;
	localparam logic [1:0] OP_MATCH_CLEAR = 2'b11;

	// Edge select codes.
	localparam logic [1:0] EDGE_FALL = 2'b00;
	localparam logic [1:0] EDGE_RISE = 2'b01;
	localparam logic [1:0] EDGE_BOTH = 2'b11;

	// Count clock sources and prescaler ratios.
	localparam logic [1:0] CLK_DIV1  = 2'b00;
	localparam logic [1:0] CLK_DIV4  = 2'b01;
	localparam logic [1:0] CLK_DIV16 = 2'b10;
	localparam logic [1:0] CLK_EDGE  = 2'b11;
	localparam logic [3:0] DIV4_LAST  = 4'h3;
	localparam logic [3:0] DIV16_LAST = 4'hF;

endpackage

// *** testbench/tec_pulse_src.sv ***
// Purpose: Far-side pulse source for the two timer edge input pins.
// Assumes: Levels change just after a rising pclk edge.
// Notes:   Every level is held two pclk cycles or more before it moves.
`timescale 1ns/1ps
`default_nettype none

module tec_pulse_src (
	input  wire logic pclk,
	output logic      pin_first,
	output logic      pin_second
);
	////////////////////////////////////////////////////////////////////////
	// Both pins idle low so the synchronisers start from a known level.
	initial begin
		pin_first = 1'b0;
		pin_second = 1'b0;
	end

	// Set one pin, then hold it; a shorter hold would be missed.
	task automatic drive(input int sel, input logic lvl, input int hold);
		int n;
		n = (hold < 2) ? 2 : hold;
		@(posedge pclk);
		if (sel == 0) begin
			pin_first <= lvl;
		end else begin
			pin_second <= lvl;
		end
		repeat (n) @(posedge pclk);
	endtask
endmodule

`default_nettype wire

// *** testbench/tb_top.sv ***
// Purpose: Self-checking bench for the 16-bit timer/event counter.
// Assumes: APB answers in its own time; count clock is pclk (ratio 1).
// Notes:   The full 65536-count wrap is run once, so the run is long.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic        pready;
	logic [31:0] prdata;
	logic        pslverr;
	logic        src_first;
	logic        src_second;
	logic        shared_pin;
	logic        timer_wave_out;
	logic        timer_wave_oe;
	logic        irq1;
	logic        irq2;
	logic        wave_d;
	logic [31:0] rd;
	logic        err;
	int          num_errors;
	int          cmp_count;
	int          cycles;
	int          n1;
	int          n2;
	int          gap_n;

	// The shared pin carries the wave only while its driver is enabled.
	assign shared_pin = timer_wave_oe ? timer_wave_out : src_second;

	tec_timer u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .edge_input_first(src_first),
		.edge_input_second(shared_pin), .timer_wave_out(timer_wave_out),
		.timer_wave_oe(timer_wave_oe), .match_irq_first(irq1),
		.match_irq_second(irq2)
	);

	tec_pulse_src u_src (
		.pclk(pclk), .pin_first(src_first), .pin_second(src_second)
	);

	////////////////////////////////////////////////////////////////////////
	// Free-running 100 MHz clock.
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Pulse counters, wave history and the hang guard.
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		wave_d <= timer_wave_out;
		if (irq1 === 1'b1) begin
			n1++;
		end
		if (irq2 === 1'b1) begin
			n2++;
		end
		if (cycles == 90000) begin
			num_errors++;
			conclude();
		end
	end

	task automatic conclude();
		$display("errors=%0d compares=%0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer; the request holds until pready is seen high.
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No wait count is assumed; only the bench timeout ends a hang.
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, e);
	endtask

	function automatic logic hit(input int sel);
		case (sel)
		0: return irq1 === 1'b1;
		1: return irq2 === 1'b1;
		default: return timer_wave_out !== wave_d;
		endcase
	endfunction

	// Cycles between two successive events of one kind.
	task automatic gap(input int sel, input int lim, output int n);
		for (int i = 0; i < 2; i++) begin
			n = 0;
			do begin
				@(posedge pclk);
				n++;
			end while (!hit(sel) && n < lim);
		end
	endtask

	// Restart with one edge code, then count captures per pin edge.
	task automatic edges(input logic [31:0] cc, input int sh, input int sel,
			input int cs, input logic [1:0] code, input int er, input int ef);
		int b;
		apb(1'b1, tec_pkg::OFS_MODE, 32'h0000_0000);
		apb(1'b1, tec_pkg::OFS_CCCTL, cc);
		apb(1'b1, tec_pkg::OFS_PRESC, 32'(code) << sh);
		apb(1'b1, tec_pkg::OFS_MODE, 32'h0000_0004);
		b = cs ? n2 : n1;
		u_src.drive(sel, 1'b1, 8);
		chk(32'((cs ? n2 : n1) - b), 32'(er));
		b = cs ? n2 : n1;
		u_src.drive(sel, 1'b0, 8);
		chk(32'((cs ? n2 : n1) - b), 32'(ef));
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence; edge code 10 is never programmed.
	initial begin
		logic [31:0] c;
		logic [31:0] c0;
		logic [1:0]  codes [3];
		int          ra [3];
		int          fa [3];
		int          rb [3];
		int          fb [3];
		codes = '{2'b00, 2'b01, 2'b11};
		ra = '{0, 1, 1};
		fa = '{1, 0, 1};
		rb = '{1, 0, 0};
		fb = '{0, 1, 0};
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		num_errors = 0;
		cmp_count = 0;
		cycles = 0;
		n1 = 0;
		n2 = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			rchk(8'(4 * i), 32'h0000_0000);
		end
		rchk(8'h1C, 32'h0000_0000);
		chk({31'h0, err}, 32'h0000_0001);
		apb(1'b1, tec_pkg::OFS_COUNT, 32'h0000_1234);
		rchk(tec_pkg::OFS_COUNT, 32'h0000_0000);
		// Captured value must sit between two counter reads.
		apb(1'b1, tec_pkg::OFS_CCCTL, 32'h0000_0004);
		apb(1'b1, tec_pkg::OFS_PRESC, 32'h0000_0010);
		apb(1'b1, tec_pkg::OFS_MODE, 32'h0000_0004);
		apb(1'b0, tec_pkg::OFS_COUNT, 32'h0000_0000);
		c0 = rd;
		rchk(tec_pkg::OFS_CMP2, 32'h0000_0000);
		u_src.drive(0, 1'b1, 8);
		apb(1'b0, tec_pkg::OFS_CMP2, 32'h0000_0000);
		c = rd;
		apb(1'b0, tec_pkg::OFS_COUNT, 32'h0000_0000);
		chk({31'h0, c > c0 && c < rd}, 32'h0000_0001);
		u_src.drive(0, 1'b0, 4);
		for (int i = 0; i < 3; i++) begin
			edges(32'h4, 4, 0, 1, codes[i], ra[i], fa[i]);
			edges(32'h3, 4, 0, 0, codes[i], rb[i], fb[i]);
			edges(32'h1, 6, 1, 0, codes[i], ra[i], fa[i]);
		end
		// Match-clear interval with both compares active.
		apb(1'b1, tec_pkg::OFS_MODE, 32'h0000_0000);
		apb(1'b1, tec_pkg::OFS_CCCTL, 32'h0000_0000);
		apb(1'b1, tec_pkg::OFS_PRESC, 32'h0000_0000);
		apb(1'b1, tec_pkg::OFS_CMP1, 32'h0000_0005);
		apb(1'b1, tec_pkg::OFS_CMP2, 32'h0000_0003);
		apb(1'b1, tec_pkg::OFS_MODE, 32'h0000_000C);
		gap(0, 300, gap_n);
		chk(32'(gap_n), 32'd6);
		gap(1, 300, gap_n);
		chk(32'(gap_n), 32'd6);
		apb(1'b1, tec_pkg::OFS_MODE, 32'h0000_0000);
		apb(1'b1, tec_pkg::OFS_CMP2, 32'h0000_FFFF);
		apb(1'b1, tec_pkg::OFS_OUTCTL, 32'h0000_0001);
		apb(1'b1, tec_pkg::OFS_MODE, 32'h0000_000C);
		gap(2, 300, gap_n);
		chk(32'(gap_n), 32'd6);
		chk({31'h0, timer_wave_oe}, 32'h0000_0001);
		apb(1'b1, tec_pkg::OFS_MODE, 32'h0000_0000);
		repeat (20) @(posedge pclk);
		rchk(tec_pkg::OFS_COUNT, 32'h0000_0000);
		chk({31'h0, timer_wave_out}, 32'h0000_0000);
		// Compare value zero matches only once per full wrap.
		apb(1'b1, tec_pkg::OFS_OUTCTL, 32'h0000_0000);
		apb(1'b1, tec_pkg::OFS_CMP1, 32'h0000_0000);
		apb(1'b1, tec_pkg::OFS_MODE, 32'h0000_0004);
		gap(0, 70000, gap_n);
		chk(32'(gap_n), 32'd65536);
		repeat (40) @(posedge pclk);
		// The one-shot enable must already be stored when the trigger lands.
		apb(1'b1, tec_pkg::OFS_OUTCTL, 32'h0000_0020);
		apb(1'b1, tec_pkg::OFS_OUTCTL, 32'h0000_0060);
		apb(1'b0, tec_pkg::OFS_COUNT, 32'h0000_0000);
		chk({31'h0, rd < 32'd12}, 32'h0000_0001);
		rchk(tec_pkg::OFS_OUTCTL, 32'h0000_0020);
		conclude();
	end
endmodule

`default_nettype wire
